// ---- rtl/eeprom_spi_front.sv ----
// ------------------------------------------------------------
// serial command sequencer
// ------------------------------------------------------------
// Behaviour
// - sample input rising edge, drive falling
// - stream bytes with auto increment
// - read address wraps to zero
// - select high stops output, aborts read
// - status read shifts status out
// - write in same frame as latch ignored
// - write address wraps within page
// - write starts only on byte boundary
// - status readable, busy high while writing
// - pause low freezes transfer state until a select edge
// - command only after select falling edge
// - output high impedance until a read
// - latch cleared at reset
// - decode the six opcodes
// - all transfers most significant bit first
// - status layout, low two bits read-only
// - latch cleared by clear command, write end
module eeprom_spi_front
  import eeprom_seq_pkg::*;
(
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        sck_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        si_in,
  input  wire logic                        pause_n_in,
  output logic                             so_out,
  output logic                             so_oe_out,
  input  wire logic [7:0]                  rd_data_in,
  output logic [eeprom_seq_pkg::ADDR_W-1:0] rd_addr_out,
  output eeprom_seq_pkg::wr_word_t         wr_word_out,
  output logic                             wr_valid_out,
  input  wire logic                        wr_ready_in,
  output logic                             wr_commit_out,
  input  wire logic                        wr_done_in,
  output logic                             busy_out,
  output logic [7:0]                       status_out
);
  import eeprom_seq_pkg::*;

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [1:0] sck_s_q, cs_s_q, si_s_q, ps_s_q;
  logic       sck_prev_q, cs_prev_q;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sck_s_q    <= 2'b00;
      cs_s_q     <= 2'b11;
      si_s_q     <= 2'b00;
      ps_s_q     <= 2'b11;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_s_q    <= {sck_s_q[0], sck_in};
      cs_s_q     <= {cs_s_q[0], cs_n_in};
      si_s_q     <= {si_s_q[0], si_in};
      ps_s_q     <= {ps_s_q[0], pause_n_in};
      sck_prev_q <= sck_s_q[1];
      cs_prev_q  <= cs_s_q[1];
    end
  end

  logic sck_rise, sck_fall, cs_fall, cs_rise, active;
  // pause gates the clock edges but not select edges, so counters hold unless select moves
  assign active   = ~cs_s_q[1] & ps_s_q[1];
  assign sck_rise = active & sck_s_q[1] & ~sck_prev_q;
  assign sck_fall = active & ~sck_s_q[1] & sck_prev_q;
  assign cs_fall  = ~cs_s_q[1] & cs_prev_q;
  assign cs_rise  = cs_s_q[1] & ~cs_prev_q;

  // ----------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------
  phase_t            ph_q, ph_d;
  logic              sel_q, sel_d;
  logic [2:0]        bit_q, bit_d;
  logic [4:0]        acnt_q, acnt_d;
  logic [7:0]        sh_q, sh_d;
  logic [7:0]        tx_q, tx_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              latch_q, latch_d;
  logic              wr_ok_q, wr_ok_d;
  logic              byte_end_q, byte_end_d;
  logic              got_data_q, got_data_d;
  logic              wr_st_q, wr_st_d;
  logic              busy_q, busy_d;
  logic [7:0]        st_nv_q, st_nv_d;
  logic              so_q, so_d, oe_q, oe_d;
  logic              push_q, push_d, commit_q, commit_d, flush_q, flush_d;
  wr_word_t          word_q, word_d;
  logic [7:0]        status_view;
  logic [7:0]        rx;
  logic              buf_ready;

  // status word; busy forces the other bits high as the part reports
  always_comb begin
    status_view              = st_nv_q & STATUS_WMASK;
    status_view[ST_LATCH]    = latch_q;
    status_view[ST_BUSY]     = busy_q;
    if (busy_q) begin
      status_view = 8'hff;
    end
  end

  // ----------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------
  always_comb begin
    ph_d = ph_q;  sel_d = sel_q;  bit_d = bit_q;  acnt_d = acnt_q;
    sh_d = sh_q;  tx_d = tx_q;  addr_d = addr_q;  latch_d = latch_q;
    wr_ok_d = wr_ok_q;
    byte_end_d = byte_end_q;  got_data_d = got_data_q;  wr_st_d = wr_st_q;
    busy_d = busy_q;  st_nv_d = st_nv_q;  so_d = so_q;  oe_d = oe_q;
    push_d = 1'b0;  commit_d = 1'b0;  flush_d = 1'b0;  word_d = word_q;
    rx = {sh_q[6:0], si_s_q[1]};

    if (wr_done_in && busy_q) begin
      busy_d  = 1'b0;
      latch_d = 1'b0;
    end

    if (cs_fall) begin
      // a frame only begins on a falling select edge
      sel_d = 1'b1;  ph_d = PH_OPCODE;  bit_d = 3'd0;
      got_data_d = 1'b0;  byte_end_d = 1'b0;
    end else if (cs_rise) begin
      oe_d  = 1'b0;
      sel_d = 1'b0;
      if (sel_q && (ph_q == PH_WR_DATA || ph_q == PH_ST_WRITE) && wr_ok_q) begin
        if (got_data_q && byte_end_q) begin
          commit_d = 1'b1;
          busy_d   = 1'b1;
          wr_st_d  = (ph_q == PH_ST_WRITE);
        end else begin
          flush_d = 1'b1;
        end
      end
      ph_d = PH_IGNORE;
    end else if (sel_q && sck_rise) begin
      sh_d       = rx;
      bit_d      = bit_q + 3'd1;
      byte_end_d = (bit_q == 3'd7);
      if (bit_q == 3'd7) begin
        unique case (ph_q)
          PH_OPCODE: begin
            unique case (rx)
              OP_LATCH_SET:    begin
                if (!busy_q) latch_d = 1'b1;
                ph_d = PH_IGNORE;
                wr_ok_d = 1'b0;
              end
              OP_LATCH_CLEAR:  begin
                if (!busy_q) latch_d = 1'b0;
                ph_d = PH_IGNORE;
              end
              OP_STATUS_READ:  begin
                ph_d = PH_ST_READ;
                tx_d = status_view;
              end
              OP_STATUS_WRITE: begin
                ph_d    = PH_ST_WRITE;
                // latch must have been set in an earlier frame
                wr_ok_d = latch_q & ~busy_q;
              end
              OP_ARRAY_READ, OP_ARRAY_WRITE: begin
                ph_d    = PH_ADDR;
                acnt_d  = 5'd0;
                wr_st_d = (rx == OP_ARRAY_WRITE);
                wr_ok_d = latch_q & ~busy_q;
              end
              default: ph_d = PH_IGNORE;
            endcase
          end
          PH_ST_WRITE: begin
            if (wr_ok_q) begin
              got_data_d = 1'b1;
              word_d     = '{is_status: 1'b1, addr: '0, data: rx & STATUS_WMASK};
              push_d     = buf_ready;
            end
          end
          PH_WR_DATA: begin
            if (wr_ok_q) begin
              got_data_d = 1'b1;
              word_d     = '{is_status: 1'b0, addr: addr_q, data: rx};
              push_d     = buf_ready;
            end
            // stay inside the page
            addr_d[PAGE_W-1:0] = addr_q[PAGE_W-1:0] + 5'd1;
          end
          PH_RD_DATA: addr_d = addr_q + 14'd1;
          default: ;
        endcase
      end
      if (ph_q == PH_ADDR) begin
        addr_d = {addr_q[ADDR_W-2:0], si_s_q[1]};
        acnt_d = acnt_q + 5'd1;
        if (acnt_q == 5'd15) begin
          ph_d = wr_st_q ? PH_WR_DATA : PH_RD_DATA;
          if (!wr_st_q) tx_d = rd_data_in;
        end
      end
    end else if (sel_q && sck_fall) begin
      if (ph_q == PH_RD_DATA || ph_q == PH_ST_READ) begin
        oe_d = 1'b1;
        so_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
        if (bit_q == 3'd0) begin
          so_d = (ph_q == PH_RD_DATA) ? rd_data_in[7] : status_view[7];
          tx_d = (ph_q == PH_RD_DATA) ? {rd_data_in[6:0], 1'b0}
                                      : {status_view[6:0], 1'b0};
        end
      end
    end

    if (commit_q && wr_st_q) begin
      st_nv_d = word_q.data;
    end
  end

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ph_q <= PH_IGNORE;  sel_q <= 1'b0;  bit_q <= 3'd0;  acnt_q <= 5'd0;
      sh_q <= 8'h00;  tx_q <= 8'h00;  addr_q <= '0;
      latch_q <= 1'b0;
      wr_ok_q <= 1'b0;  byte_end_q <= 1'b0;
      got_data_q <= 1'b0;  wr_st_q <= 1'b0;  busy_q <= 1'b0;
      st_nv_q <= STATUS_RESET;  so_q <= 1'b0;
      oe_q <= 1'b0;
      push_q <= 1'b0;  commit_q <= 1'b0;  flush_q <= 1'b0;  word_q <= '0;
    end else begin
      ph_q <= ph_d;  sel_q <= sel_d;  bit_q <= bit_d;  acnt_q <= acnt_d;
      sh_q <= sh_d;  tx_q <= tx_d;  addr_q <= addr_d;  latch_q <= latch_d;
      wr_ok_q <= wr_ok_d;
      byte_end_q <= byte_end_d;  got_data_q <= got_data_d;  wr_st_q <= wr_st_d;
      busy_q <= busy_d;  st_nv_q <= st_nv_d;  so_q <= so_d;  oe_q <= oe_d;
      push_q <= push_d;  commit_q <= commit_d;  flush_q <= flush_d;
      word_q <= word_d;
    end
  end

  // ----------------------------------------------------------
  // word buffer toward the array
  // ----------------------------------------------------------
  wr_word_t          buf_word;
  logic              buf_valid;
  logic              buf_take;
  logic [ADDR_W-1:0] rd_addr_q;
  wr_word_t          wr_word_q;
  logic              wr_valid_q;
  // output stage refills when empty or when the array takes its word
  assign buf_take = ~wr_valid_q | wr_ready_in;
  eeprom_word_buffer u_buf (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .flush_in      (flush_q),
    .in_word_in    (word_q),
    .in_valid_in   (push_q),
    .in_ready_out  (buf_ready),
    .out_word_out  (buf_word),
    .out_valid_out (buf_valid),
    .out_ready_in  (buf_take)
  );

  // outputs straight from flops; a cancelled sequence drops the staged word too
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_addr_q  <= '0;
      wr_word_q  <= '0;
      wr_valid_q <= 1'b0;
    end else begin
      rd_addr_q  <= addr_d;
      wr_word_q  <= buf_take ? buf_word : wr_word_q;
      wr_valid_q <= ~flush_q & (buf_take ? buf_valid : wr_valid_q);
    end
  end
  assign rd_addr_out   = rd_addr_q;
  assign wr_word_out   = wr_word_q;
  assign wr_valid_out  = wr_valid_q;
  assign wr_commit_out = commit_q;
  assign so_out        = so_q;
  assign so_oe_out     = oe_q;
  assign busy_out      = busy_q;
  assign status_out    = st_nv_q;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  chk_oe_off_desel: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    cs_rise |=> !so_oe_out) else $error("output driven after deselect");
  chk_latch_reset: assert property (@(posedge sys_clk_in)
    rst_in |=> !latch_q) else $error("latch not cleared by reset");
  chk_oe_reset: assert property (@(posedge sys_clk_in)
    rst_in |=> !so_oe_out) else $error("output enabled at reset");
  chk_busy_status: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    busy_q |-> status_view[ST_BUSY]) else $error("busy not reported");
  chk_commit_busy: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    commit_q |-> busy_q) else $error("commit without busy");
  chk_pause_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!ps_s_q[1] && !cs_s_q[1] && !cs_prev_q) |=> $stable(bit_q))
    else $error("state moved in pause");
  chk_done_clears: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (wr_done_in && busy_q) |=> !latch_q) else $error("latch kept after write");
  chk_no_unlatched: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    commit_q |-> $past(wr_ok_q)) else $error("write without latch");
endmodule

// ---- rtl/eeprom_seq_pkg.sv ----
package eeprom_seq_pkg;
  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;

  // ------------------------------------------------------------
  // array geometry and status layout
  // ------------------------------------------------------------
  localparam int          ADDR_W        = 14;
  localparam int          PAGE_W        = 5;
  localparam int          ST_PIN_PROT   = 7;
  localparam int          ST_BLOCK_HI   = 3;
  localparam int          ST_BLOCK_LO   = 2;
  localparam int          ST_LATCH      = 1;
  localparam int          ST_BUSY       = 0;
  localparam logic [7:0]  STATUS_WMASK  = 8'h8c;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 40;

  // one word handed to the array side
  typedef struct packed {
    logic             is_status;
    logic [ADDR_W-1:0] addr;
    logic [7:0]       data;
  } wr_word_t;

  // decoded command phase
  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR, PH_RD_DATA, PH_WR_DATA, PH_ST_READ, PH_ST_WRITE, PH_IGNORE
  } phase_t;
endpackage

// ---- rtl/eeprom_word_buffer.sv ----
// two-entry buffer between the serial front end and the array write port
module eeprom_word_buffer
  import eeprom_seq_pkg::*;
(
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     flush_in,
  input  wire eeprom_seq_pkg::wr_word_t in_word_in,
  input  wire logic                     in_valid_in,
  output logic                          in_ready_out,
  output eeprom_seq_pkg::wr_word_t      out_word_out,
  output logic                          out_valid_out,
  input  wire logic                     out_ready_in
);
  wr_word_t   mem_q [2];
  wr_word_t   mem_d [2];
  logic       wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic       push, pop;

  // ----------------------------------------------------------
  // pointer and count update
  // ----------------------------------------------------------
  always_comb begin
    push  = in_valid_in && (cnt_q != 2'd2);
    pop   = out_valid_out && out_ready_in;
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_word_in;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    if (flush_in) begin
      // an aborted sequence drops whatever the array has not taken yet
      wp_d  = 1'b0;
      rp_d  = 1'b0;
      cnt_d = 2'd0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end

  assign in_ready_out  = (cnt_q != 2'd2);
  assign out_valid_out = (cnt_q != 2'd0);
  assign out_word_out  = mem_q[rp_q];
endmodule

// ---- testbench/spi_host_model.sv ----
// spi host on the far side: mode 0, clock parked low outside frames
module spi_host_model (
  input  wire logic sys_clk_in,
  input  wire logic so_in,
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  output logic      pause_n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // idle pins
  // ------------------------------------------------------------
  initial begin
    sck_out     = 1'b0;
    cs_n_out    = 1'b1;
    si_out      = 1'b0;
    pause_n_out = 1'b1;
  end

  // pins move only just after a falling system clock edge
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  task automatic sel();
    tick(4);
    cs_n_out = 1'b0;
    tick(4);
  endtask

  // released data line flips so a stale value cannot pass for data
  task automatic desel();
    tick(4);
    cs_n_out = 1'b1;
    si_out   = ~si_out;
    tick(12);
  endtask

  // ------------------------------------------------------------
  // shift nb bits, msb first; pause before bit pb if asked
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, input int nb, input int pb,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      if (i == pb) begin
        tick(4); // let the last clock fall land before pausing
        pause_n_out = 1'b0; // clock is low here
        tick(4);
        sck_out = 1'b1; // shared clock keeps running, must be ignored
        si_out  = ~si_out;
        tick(4);
        sck_out = 1'b0;
        tick(4);
        pause_n_out = 1'b1;
        tick(4);
      end
      si_out = tx[i];
      tick(4);
      sck_out = 1'b1;
      tick(4);
      rx[i]   = so_in; // sampled before the fall
      sck_out = 1'b0;
    end
  endtask
endmodule

// ---- testbench/tb_spi_eeprom_command_sequencer.sv ----
module tb_spi_eeprom_command_sequencer import eeprom_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef logic [7:0] bytes_t[$];
  logic              sys_clk, rst, sck, cs_n, si, pause_n, so, so_oe, so_pin;
  logic [7:0]        rd_data, status, rx;
  logic [ADDR_W-1:0] rd_addr;
  wr_word_t          wr_word;
  wr_word_t          words[$];
  logic              wr_valid, wr_ready, wr_commit, wr_done, busy, stall;
  int                fail_count, cmp_count;
  int                cycles  = 0;
  int                commits = 0;

  // array contents: a fixed pattern of the address
  function automatic logic [7:0] mem_at(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ {2'h0, a[13:8]} ^ 8'h5a;
  endfunction

  assign rd_data  = mem_at(rd_addr);
  assign wr_ready = stall ? (cycles[2:0] == 3'h0) : 1'b1; // slow array side
  // undriven data line shows the inverse of the last bit, not stale data
  assign so_pin   = so_oe ? so : ~so;

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  eeprom_spi_front i_eeprom_spi_front (
    .sys_clk_in    (sys_clk),
    .rst_in        (rst),
    .sck_in        (sck),
    .cs_n_in       (cs_n),
    .si_in         (si),
    .pause_n_in    (pause_n),
    .so_out        (so),
    .so_oe_out     (so_oe),
    .rd_data_in    (rd_data),
    .rd_addr_out   (rd_addr),
    .wr_word_out   (wr_word),
    .wr_valid_out  (wr_valid),
    .wr_ready_in   (wr_ready),
    .wr_commit_out (wr_commit),
    .wr_done_in    (wr_done),
    .busy_out      (busy),
    .status_out    (status)
  );

  spi_host_model i_spi_host_model (
    .sys_clk_in  (sys_clk),
    .so_in       (so_pin),
    .sck_out     (sck),
    .cs_n_out    (cs_n),
    .si_out      (si),
    .pause_n_out (pause_n)
  );

  // ------------------------------------------------------------
  // monitors and hang guard
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) words.push_back(wr_word);
    if (wr_commit === 1'b1) commits <= commits + 1;
    if (cycles == 30000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic check_word(input wr_word_t got, input wr_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic send(input logic [7:0] b);
    i_spi_host_model.xfer(b, 8, -1, rx);
  endtask

  task automatic frame(input bytes_t b);
    i_spi_host_model.sel();
    foreach (b[i]) send(b[i]);
    i_spi_host_model.desel();
  endtask

  task automatic rd_status(output logic [7:0] v);
    i_spi_host_model.sel();
    send(OP_STATUS_READ);
    i_spi_host_model.xfer(8'h00, 8, -1, v);
    i_spi_host_model.desel();
  endtask

  // busy until the array reports done, then latch drops
  task automatic finish_write();
    repeat (8) @(negedge sys_clk);
    check_flag(busy, 1'b1);
    rd_status(rx);
    check8(rx, 8'hff);
    wr_done = 1'b1;
    @(negedge sys_clk);
    wr_done = 1'b0;
    repeat (4) @(negedge sys_clk);
    check_flag(busy, 1'b0);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst        = 1'b1;
    wr_done    = 1'b0;
    stall      = 1'b0;
    fail_count = 0;
    cmp_count  = 0;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    check_flag(so_oe, 1'b0);
    // clocks without a select edge are no command
    send(OP_LATCH_SET);
    rd_status(rx);
    check8(rx, 8'h00);
    frame('{OP_ARRAY_WRITE, 8'h00, 8'h10, 8'h33});
    check8(8'(commits), 8'h00);
    frame('{OP_LATCH_SET});
    rd_status(rx);
    check8(rx, 8'h02);
    frame('{OP_LATCH_CLEAR});
    rd_status(rx);
    check8(rx, 8'h00);
    // write run on in the latch frame is dropped
    frame('{OP_LATCH_SET, OP_ARRAY_WRITE, 8'h00, 8'h10, 8'h33});
    check8(8'(commits), 8'h00);
    // deselect three bits into a data byte cancels
    frame('{OP_LATCH_SET});
    i_spi_host_model.sel();
    send(OP_ARRAY_WRITE);
    send(8'h01);
    send(8'h20);
    send(8'h44);
    i_spi_host_model.xfer(8'h55, 3, -1, rx);
    i_spi_host_model.desel();
    check8(8'(commits), 8'h00);
    // page write crossing the page end, array side stalling
    frame('{OP_LATCH_SET});
    words.delete();
    stall = 1'b1;
    frame('{OP_ARRAY_WRITE, 8'h01, 8'h3e, 8'ha1, 8'ha2, 8'ha3});
    repeat (40) @(negedge sys_clk);
    stall = 1'b0;
    check8(8'(commits), 8'h01);
    check8(8'(words.size()), 8'h03);
    check_word(words[0], {1'b0, 14'h013e, 8'ha1});
    check_word(words[1], {1'b0, 14'h013f, 8'ha2});
    check_word(words[2], {1'b0, 14'h0120, 8'ha3});
    finish_write();
    rd_status(rx);
    check8(rx, 8'h00);
    // status write of the three writable bits
    frame('{OP_LATCH_SET});
    frame('{OP_STATUS_WRITE, 8'h8c});
    repeat (8) @(negedge sys_clk);
    check8(8'(commits), 8'h02);
    finish_write();
    check8(status, 8'h8c);
    rd_status(rx);
    check8(rx, 8'h8c);
    // read from 3ffe with high address bits set, wrap and a pause
    i_spi_host_model.sel();
    send(OP_ARRAY_READ);
    send(8'hff);
    send(8'hfe);
    for (int k = 0; k < 4; k++) begin
      i_spi_host_model.xfer(8'h00, 8, (k == 2) ? 4 : -1, rx);
      check8(rx, mem_at(14'(14'h3ffe + k)));
    end
    check_flag(so_oe, 1'b1);
    i_spi_host_model.desel();
    check_flag(so_oe, 1'b0);
    // unknown opcode silences the frame
    i_spi_host_model.sel();
    send(8'ha5);
    send(OP_STATUS_READ);
    send(8'h00);
    check_flag(so_oe, 1'b0);
    i_spi_host_model.desel();
    rd_status(rx);
    check8(rx, 8'h8c);
    report_and_stop();
  end
endmodule
